// File: src/sdis_ctrl.sv
// Purpose: power-up init and self-refresh sequencer for x16 sdram
// Assumes: clock_i also drives the sdram clock pin through clk_en_o
// Notes:   no register bus; requests arrive as pin levels
//
// Notes on behaviour
// - power-up: cke low, dqm high, nop
// - clock stable 200 us before cke
// - keep dqm high during stabilisation
// - precharge all before mode programming
// - issue extended and normal mode set
// - at least two init auto-refreshes
// - refreshes may precede or follow mode set
// - entry: cs ras cas low, cke low
// - hold self refresh at least tras
// - restart clock, stable before cke high
// - chip select high as cke rises
// - wait exit time before any command
// - optional 4096 burst refreshes around self refresh
// - exit wait is trc plus tis
// - tras is 42 ns, slower grade
// - two cycles after each mode set
`timescale 1ns/10ps
`default_nettype none
module sdis_ctrl #(
    parameter int unsigned STABLE_CYCLES = sdis_pkg::STABLE_CYC,
    parameter int unsigned BURST_COUNT   = sdis_pkg::BURST_REFRESHES,
    parameter int unsigned INIT_REFS     = sdis_pkg::INIT_REFRESHES,
    parameter bit          REF_AFTER_MRS = 1'b0,
    parameter logic [12:0] MODE_VALUE    = 13'h0023,
    parameter logic [12:0] EXT_VALUE     = 13'h0000
) (
    input  wire logic        clock_i,
    input  wire logic        rst_i,
    input  wire logic        sr_req_i,
    input  wire logic        burst_ref_i,
    output var  logic        clk_en_o,
    output var  logic        cke_o,
    output var  logic        cs_n_o,
    output var  logic        ras_n_o,
    output var  logic        cas_n_o,
    output var  logic        we_n_o,
    output var  logic [1:0]  ba_o,
    output var  logic [12:0] addr_o,
    output var  logic [1:0]  dqm_o,
    output var  logic        ready_o,
    output var  logic        in_sr_o
);
    import sdis_pkg::*;

    // refuse settings the sixteen-bit tally and the timer cannot serve
    if (STABLE_CYCLES < 1) begin : g_bad_stable
        $error("sdis_ctrl: STABLE_CYCLES below one");
    end
    if (BURST_COUNT < 1 || BURST_COUNT > 32'h0000_ffff) begin : g_bad_burst
        $error("sdis_ctrl: BURST_COUNT out of range");
    end
    if (INIT_REFS < 2 || INIT_REFS > 32'h0000_ffff) begin : g_bad_init
        $error("sdis_ctrl: INIT_REFS out of range");
    end

    typedef enum logic [3:0] {
        ST_POWER, ST_PREALL, ST_REF_A, ST_EMRS, ST_MRS, ST_REF_B,
        ST_IDLE, ST_BURST_IN, ST_SR_ENTER, ST_SR_HOLD, ST_CLK_RUN,
        ST_CKE_UP, ST_XSR, ST_BURST_OUT
    } sdis_state_e;

    ////////////////////////////////////////////////////////////////////
    sdis_tmr_if tmr ();
    sdis_timer u_timer (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .t       (tmr)
    );

    // request pins are asynchronous to clock_i
    logic [1:0] req_s;
    sdis_sync #(.W(2)) u_sync (
        .clock_i (clock_i),
        .rst_i   (rst_i),
        .d_i     ({burst_ref_i, sr_req_i}),
        .q_o     (req_s)
    );
    wire sr_req    = req_s[0];
    wire burst_req = req_s[1];

    ////////////////////////////////////////////////////////////////////
    sdis_state_e state_r, state_nxt;
    logic [15:0] refs_r;
    logic [3:0]  cmd_nxt;
    logic [1:0]  ba_nxt;
    logic [12:0] addr_nxt;
    logic        cke_nxt;
    logic        clk_en_nxt;
    logic        load_nxt;
    logic [31:0] count_nxt;
    logic        refs_clr;
    logic        refs_inc;
    // state decodes used outside the case
    wire         st_hold = (state_r == ST_SR_HOLD);
    wire         st_xsr  = (state_r == ST_XSR);

    function automatic logic [31:0] wait_of(input logic [3:0] cmd);
        unique case (cmd)
            CMD_PREALL:  wait_of = 32'(RP_CYC);
            CMD_REFRESH: wait_of = 32'(RC_CYC);
            CMD_MRS:     wait_of = 32'(T_MRD_CK);
            default:     wait_of = 32'h1;
        endcase
    endfunction : wait_of

    // true on the refresh that completes a run of target commands
    function automatic logic last_of(input logic [15:0] refs,
                                     input logic [15:0] target);
        last_of = (refs + 16'h1 >= target);
    endfunction : last_of

    // done compares only the registered count, so go never loops back through load
    wire go = tmr.done;
    wire [15:0] init_target  = 16'(INIT_REFS);
    wire [15:0] burst_target = 16'(BURST_COUNT);

    always_comb begin
        state_nxt  = state_r;
        cmd_nxt    = CMD_NOP;
        ba_nxt     = 2'h0;
        addr_nxt   = 13'h0;
        cke_nxt    = cke_o;
        clk_en_nxt = clk_en_o;
        load_nxt   = 1'b0;
        count_nxt  = 32'h1;
        refs_clr   = 1'b0;
        refs_inc   = 1'b0;
        if (go) begin
            unique case (state_r)
                ST_POWER: begin
                    // clock already runs; cke up after stability
                    cke_nxt   = 1'b1;
                    state_nxt = ST_PREALL;
                end
                ST_PREALL: begin
                    cmd_nxt           = CMD_PREALL;
                    addr_nxt[A10_BIT] = 1'b1;
                    refs_clr          = 1'b1;
                    state_nxt = REF_AFTER_MRS ? ST_EMRS : ST_REF_A;
                end
                ST_REF_A, ST_REF_B: begin
                    cmd_nxt  = CMD_REFRESH;
                    refs_inc = 1'b1;
                    if (last_of(refs_r, init_target)) begin
                        refs_clr  = 1'b1;
                        state_nxt = (state_r == ST_REF_A) ? ST_EMRS
                                                          : ST_IDLE;
                    end
                end
                ST_EMRS: begin
                    cmd_nxt   = CMD_MRS;
                    ba_nxt    = BA_EXT;
                    addr_nxt  = EXT_VALUE;
                    state_nxt = ST_MRS;
                end
                ST_MRS: begin
                    cmd_nxt   = CMD_MRS;
                    ba_nxt    = BA_MODE;
                    addr_nxt  = MODE_VALUE;
                    state_nxt = REF_AFTER_MRS ? ST_REF_B : ST_IDLE;
                end
                ST_IDLE: begin
                    refs_clr = 1'b1;
                    if (sr_req)
                        state_nxt = burst_req ? ST_BURST_IN
                                              : ST_SR_ENTER;
                end
                ST_BURST_IN, ST_BURST_OUT: begin
                    cmd_nxt  = CMD_REFRESH;
                    refs_inc = 1'b1;
                    if (last_of(refs_r, burst_target)) begin
                        refs_clr  = 1'b1;
                        state_nxt = (state_r == ST_BURST_IN) ? ST_SR_ENTER
                                                             : ST_IDLE;
                    end
                end
                ST_SR_ENTER: begin
                    cmd_nxt   = CMD_REFRESH;
                    cke_nxt   = 1'b0;
                    count_nxt = 32'(RAS_CYC);
                    load_nxt  = 1'b1;
                    state_nxt = ST_SR_HOLD;
                end
                ST_SR_HOLD: begin
                    // device runs its own refresh while cke low
                    clk_en_nxt = 1'b0;
                    // exit starts once the synchronised request drops
                    if (!sr_req) begin
                        clk_en_nxt = 1'b1;
                        count_nxt  = 32'h2;
                        load_nxt   = 1'b1;
                        state_nxt  = ST_CLK_RUN;
                    end
                end
                ST_CLK_RUN: begin
                    cmd_nxt   = CMD_DESEL;
                    cke_nxt   = 1'b1;
                    state_nxt = ST_CKE_UP;
                end
                ST_CKE_UP: begin
                    cmd_nxt   = CMD_DESEL;
                    count_nxt = 32'(XSR_CYC);
                    load_nxt  = 1'b1;
                    state_nxt = ST_XSR;
                end
                ST_XSR: begin
                    state_nxt = burst_req ? ST_BURST_OUT : ST_IDLE;
                end
                default: state_nxt = ST_POWER;
            endcase
            // each command arms the timer with its own least spacing unless its state loaded a wait already
            if (!load_nxt && cmd_nxt != CMD_NOP) begin
                count_nxt = wait_of(cmd_nxt);
                load_nxt  = 1'b1;
            end
        end else if (st_hold || st_xsr) begin
            cmd_nxt = CMD_DESEL;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // power-up wait is loaded once, in the first cycle out of reset
    logic       rst_hold_r;
    wire        power_load = (state_r == ST_POWER) && rst_hold_r;
    wire        nxt_idle   = (state_nxt == ST_IDLE);
    wire        nxt_hold   = (state_nxt == ST_SR_HOLD);
    // pins keep their power-up levels until the sequence starts
    wire [3:0]  cmd_out    = rst_hold_r ? CMD_NOP : cmd_nxt;
    wire        cke_out    = rst_hold_r ? 1'b0 : cke_nxt;
    wire        clk_en_out = rst_hold_r ? 1'b1 : clk_en_nxt;
    wire        ready_out  = nxt_idle && !rst_hold_r;
    wire        in_sr_out  = nxt_hold && !rst_hold_r;

    assign tmr.load  = power_load || load_nxt;
    assign tmr.count = power_load ? 32'(STABLE_CYCLES) : count_nxt;

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            state_r    <= ST_POWER;
            rst_hold_r <= 1'b1;
        end else begin
            state_r    <= rst_hold_r ? ST_POWER : state_nxt;
            rst_hold_r <= 1'b0;
        end
    end

    // a clear in the same cycle as a count wins: the run is over
    always_ff @(posedge clock_i) begin
        if (rst_i || refs_clr)
            refs_r <= 16'h0;
        else if (refs_inc)
            refs_r <= refs_r + 16'h1;
    end

    ////////////////////////////////////////////////////////////////////
    // clock gate and cke change on the same edge as the command pins
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cke_o    <= 1'b0;
            clk_en_o <= 1'b1;
        end else begin
            cke_o    <= cke_out;
            clk_en_o <= clk_en_out;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= CMD_NOP;
            ba_o   <= 2'h0;
            addr_o <= 13'h0;
        end else begin
            {cs_n_o, ras_n_o, cas_n_o, we_n_o} <= cmd_out;
            ba_o   <= ba_nxt;
            addr_o <= addr_nxt;
        end
    end

    // status follows the next state so it lines up with the pins
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            dqm_o   <= 2'h3;
            ready_o <= 1'b0;
            in_sr_o <= 1'b0;
        end else begin
            // no data phase here, so the masks never drop
            dqm_o   <= 2'h3;
            ready_o <= ready_out;
            in_sr_o <= in_sr_out;
        end
    end
endmodule : sdis_ctrl
`default_nettype wire

// File: common/sdis_pkg.sv
// Purpose: constants for the sdram init and self-refresh sequencer
// Assumes: 40 MHz clock, 25 ns period
// Notes:   command encodings are {cs_n, ras_n, cas_n, we_n}
package sdis_pkg;
    localparam int unsigned CLK_PERIOD_PS   = 25000;
    // times as printed, in their own unit
    localparam int unsigned T_STABLE_US     = 200;
    localparam int unsigned T_RC_PS         = 60000;
    localparam int unsigned T_IS_PS         = 1500;
    localparam int unsigned T_RAS_PS        = 42000;
    localparam int unsigned T_RP_PS         = 18000;
    localparam int unsigned T_MRD_CK        = 2;
    localparam int unsigned INIT_REFRESHES  = 2;
    localparam int unsigned BURST_REFRESHES = 4096;
    // least times round up to whole cycles
    localparam int unsigned STABLE_CYC =
        (T_STABLE_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int unsigned RC_CYC  = (T_RC_PS + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
    localparam int unsigned XSR_CYC = (T_RC_PS + T_IS_PS + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
    localparam int unsigned RAS_CYC = (T_RAS_PS + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
    localparam int unsigned RP_CYC  = (T_RP_PS + CLK_PERIOD_PS - 1)
                                      / CLK_PERIOD_PS;
    localparam int unsigned TW      = 16;
    localparam logic [3:0] CMD_DESEL   = 4'hf;
    localparam logic [3:0] CMD_NOP     = 4'h7;
    localparam logic [3:0] CMD_PREALL  = 4'h2;
    localparam logic [3:0] CMD_REFRESH = 4'h1;
    localparam logic [3:0] CMD_MRS     = 4'h0;
    localparam int unsigned A10_BIT    = 10;
    localparam logic [1:0] BA_MODE     = 2'h0;
    localparam logic [1:0] BA_EXT      = 2'h2;
endpackage : sdis_pkg

// File: common/sdis_tmr_if.sv
// Purpose: start/done link between sequencer and its wait timer
// Assumes: one clock domain
// Notes:   load is a one-cycle pulse, done is a level
`timescale 1ns/10ps
`default_nettype none
interface sdis_tmr_if;
    logic        load;
    logic [31:0] count;
    logic        done;
    modport ctl (output load, output count, input done);
    modport tmr (input load, input count, output done);
endinterface : sdis_tmr_if
`default_nettype wire

// File: src/sdis_timer.sv
// Purpose: down counter for the sequencer's least waits
// Assumes: count of at least one cycle
// Notes:   done rises count cycles after load
`timescale 1ns/10ps
`default_nettype none
module sdis_timer (
    input  wire logic clock_i,
    input  wire logic rst_i,
    sdis_tmr_if.tmr   t
);
    import sdis_pkg::*;
    logic [31:0] cnt_r;
    always_ff @(posedge clock_i) begin
        if (rst_i)
            cnt_r <= 32'h0;
        else if (t.load)
            cnt_r <= t.count;
        else if (cnt_r != 32'h0)
            cnt_r <= cnt_r - 32'h1;
    end
    // combinational compare of the register only, so the caller may load from done freely
    assign t.done = (cnt_r == 32'h0);
endmodule : sdis_timer
`default_nettype wire

// File: src/sdis_sync.sv
// Purpose: two-flop synchroniser for request pins
// Assumes: level inputs
// Notes:   first stage is read only by the second
`timescale 1ns/10ps
`default_nettype none
module sdis_sync #(
    parameter int unsigned W = 2
) (
    input  wire logic         clock_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output var  logic [W-1:0] q_o
);
    logic [W-1:0] s1_r;
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            s1_r <= '0;
            q_o  <= '0;
        end else begin
            s1_r <= d_i;
            q_o  <= s1_r;
        end
    end
endmodule : sdis_sync
`default_nettype wire

// File: testbench/sdis_ctrl_assertions.sv
// Purpose: pin sequencing checks for sdis_ctrl
// Assumes: one clock, sync reset
// Notes:   bound to sdis_ctrl at the foot
`timescale 1ns/10ps
`default_nettype none
module sdis_ctrl_assertions
    import sdis_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = 10
) (
    input wire logic        clock_i,
    input wire logic        rst_i,
    input wire logic        clk_en_o,
    input wire logic        cke_o,
    input wire logic        cs_n_o,
    input wire logic        ras_n_o,
    input wire logic        cas_n_o,
    input wire logic        we_n_o,
    input wire logic [1:0]  ba_o,
    input wire logic [12:0] addr_o,
    input wire logic [1:0]  dqm_o,
    input wire logic        ready_o
);
    wire logic [3:0] cmd_w  = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
    wire logic       idle_w = cs_n_o || (cmd_w == CMD_NOP);
    wire logic       mrs_w  = (cmd_w == CMD_MRS);
    logic [31:0]     cyc_r;
    logic [1:0]      refs_r;
    logic            pre_r, emrs_r, mrs_r, done_r;
    ////////////////////////////////////////////////////////////////////////
    // cycle count, saturating refresh count and sticky flags, never cleared but by reset
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            cyc_r  <= '0;
            refs_r <= '0;
            {pre_r, emrs_r, mrs_r, done_r} <= '0;
        end else begin
            cyc_r  <= cyc_r + 32'h1;
            if (cmd_w == CMD_REFRESH && cke_o && refs_r != 2'h3)
                refs_r <= refs_r + 2'h1;
            pre_r  <= pre_r || (cmd_w == CMD_PREALL && addr_o[A10_BIT]);
            emrs_r <= emrs_r || (mrs_w && ba_o == BA_EXT);
            mrs_r  <= mrs_r || (mrs_w && ba_o == BA_MODE);
            done_r <= done_r || ready_o;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    default clocking @(posedge clock_i); endclocking
    default disable iff (rst_i);
    AST_DQM_HIGH: assert property (dqm_o == 2'h3)
        else $error("dqm not high");
    AST_STABLE: assert property ($rose(cke_o) && !done_r |->
        cyc_r >= STABLE_CYCLES) else $error("cke rose too early");
    AST_PRE_FIRST: assert property (mrs_w |-> pre_r)
        else $error("mode set before precharge all");
    AST_INIT_DONE: assert property ($rose(ready_o) |->
        emrs_r && (mrs_r || mrs_w) && refs_r >= 2'h2)
        else $error("init incomplete");
    AST_ENTRY: assert property ($fell(cke_o) |->
        cmd_w == CMD_REFRESH) else $error("bad entry command");
    AST_HOLD: assert property ($fell(cke_o) |=> !cke_o [*2])
        else $error("self refresh too short");
    AST_CLK_FIRST: assert property ($rose(cke_o) |-> clk_en_o &&
        $past(clk_en_o) && $past(clk_en_o, 2)) else $error("clock late");
    AST_EXIT_CS: assert property ($rose(cke_o) && done_r |-> cs_n_o)
        else $error("cs low at exit");
    AST_EXIT_WAIT: assert property ($rose(cke_o) && done_r |->
        idle_w [*3]) else $error("command in exit wait");
    AST_MRD: assert property (mrs_w |=> idle_w)
        else $error("command too soon after mode set");
    cover property ($rose(ready_o));
    cover property ($fell(cke_o));
    cover property ($rose(cke_o) && done_r);
endmodule : sdis_ctrl_assertions
bind sdis_ctrl sdis_ctrl_assertions #(.STABLE_CYCLES(STABLE_CYCLES)) u_chk (
    .clock_i(clock_i), .rst_i(rst_i), .clk_en_o(clk_en_o), .cke_o(cke_o),
    .cs_n_o(cs_n_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o), .we_n_o(we_n_o),
    .ba_o(ba_o), .addr_o(addr_o), .dqm_o(dqm_o), .ready_o(ready_o));
`default_nettype wire

// File: testbench/sdis_sdram_model.sv
// Purpose: behavioural sdram for init and self refresh
// Assumes: free-running clock; clk_en_i low stands for a stopped clock
// Notes:   counts misuse in faults_o
`timescale 1ns/10ps
`default_nettype none
module sdis_sdram_model
    import sdis_pkg::*;
#(
    parameter int unsigned STABLE_CYCLES = 10
) (
    input  wire logic       clock_i,
    input  wire logic       clk_en_i,
    input  wire logic       cke_i,
    input  wire logic [3:0] cmd_i,
    input  wire logic       a10_i,
    output var  logic       sr_o,
    output var  int         faults_o
);
    int   run_r = 0, hold_r = 0, wait_r = 0, refs_r = 0;
    logic up_r = 0, pre_r = 0;
    initial sr_o = 1'b0;
    initial faults_o = 0;
    ////////////////////////////////////////////////////////////////////////
    // in self refresh only cke is looked at, clock may stop
    always @(posedge clock_i) begin
        if (sr_o) begin
            hold_r <= hold_r + 1;
            if (cke_i) begin
                sr_o   <= 1'b0;
                wait_r <= XSR_CYC - 1;
                if (hold_r < RAS_CYC) faults_o <= faults_o + 1;
            end
        end else if (clk_en_i) begin
            run_r <= run_r + 1;
            if (!up_r && cke_i) up_r <= 1'b1;
            if (!up_r && cke_i && run_r < STABLE_CYCLES)
                faults_o <= faults_o + 1;
            if (wait_r != 0) wait_r <= wait_r - 1;
            if (wait_r != 0 && !cmd_i[3] && cmd_i != CMD_NOP)
                faults_o <= faults_o + 1;
            if (cmd_i == CMD_PREALL && a10_i) pre_r <= 1'b1;
            if (cmd_i == CMD_MRS && !pre_r) faults_o <= faults_o + 1;
            // refreshes taken before or after mode set alike
            if (cmd_i == CMD_REFRESH && cke_i) refs_r <= refs_r + 1;
            if (cmd_i == CMD_REFRESH && !cke_i && up_r) begin
                sr_o   <= 1'b1;
                hold_r <= 0;
            end
        end
    end
endmodule : sdis_sdram_model
`default_nettype wire

// File: testbench/sdis_ctrl_bench.sv
// Purpose: self-checking bench for sdis_ctrl
// Assumes: 40 MHz clock, short stable and burst counts
// Notes:   commands with cs low, nop aside, are logged for order checks
`timescale 1ns/10ps
`default_nettype none
module sdis_ctrl_bench;
    import sdis_pkg::*;
    localparam int STB = 20;
    localparam int BUR = 4;
    logic        clock_i = 0, rst_i = 1, sr_req_i = 0, burst_ref_i = 0;
    logic        clk_en_o, cke_o, cs_n_o, ras_n_o, cas_n_o, we_n_o;
    logic        ready_o, in_sr_o, sr_m;
    logic [1:0]  ba_o, dqm_o;
    logic [12:0] addr_o;
    logic [18:0] log_q[$];
    int          faults_m, err_total = 0, num_checks = 0, cyc = 0;
    wire logic [3:0] cmd_w = {cs_n_o, ras_n_o, cas_n_o, we_n_o};
    always #12.5 clock_i = ~clock_i;
    sdis_ctrl #(.STABLE_CYCLES(STB), .BURST_COUNT(BUR)) dut (
        .clock_i(clock_i), .rst_i(rst_i), .sr_req_i(sr_req_i),
        .burst_ref_i(burst_ref_i), .clk_en_o(clk_en_o), .cke_o(cke_o),
        .cs_n_o(cs_n_o), .ras_n_o(ras_n_o), .cas_n_o(cas_n_o),
        .we_n_o(we_n_o), .ba_o(ba_o), .addr_o(addr_o), .dqm_o(dqm_o),
        .ready_o(ready_o), .in_sr_o(in_sr_o));
    sdis_sdram_model #(.STABLE_CYCLES(STB)) mem (
        .clock_i(clock_i), .clk_en_i(clk_en_o), .cke_i(cke_o),
        .cmd_i(cmd_w), .a10_i(addr_o[A10_BIT]), .sr_o(sr_m),
        .faults_o(faults_m));
    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock_i)
        if (!rst_i && !cs_n_o && cmd_w != CMD_NOP)
            log_q.push_back({cmd_w, ba_o, addr_o});
    // whole run is under two hundred cycles
    always @(posedge clock_i) begin
        cyc++;
        if (cyc == 3000) begin
            err_total++;
            conclude();
        end
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock_i);
        #1;
    endtask : tick
    task automatic check(input string what, input logic [31:0] seen,
                         input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    ////////////////////////////////////////////////////////////////////////
    task automatic t_init();
        int i;
        int up;
        up = 0;
        tick(10);
        check("reset cke", cke_o, 0);
        check("reset cmd", cmd_w, CMD_NOP);
        check("reset dqm", dqm_o, 2'h3);
        log_q.delete();
        rst_i = 0;
        for (i = 0; i < 300 && ready_o !== 1'b1; i++) begin
            tick(1);
            if (cke_o !== 1'b1) up++;
        end
        // ready rises with the mode set; let the log take it
        tick(1);
        check("ready", ready_o, 1);
        check("cycles before cke", up >= STB, 1);
        check("init count", log_q.size(), 5);
        check("preall", log_q[0][18:15], CMD_PREALL);
        check("a10", log_q[0][10], 1);
        check("ref 1", log_q[1][18:15], CMD_REFRESH);
        check("ref 2", log_q[2][18:15], CMD_REFRESH);
        check("emrs", log_q[3], {CMD_MRS, BA_EXT, 13'h0000});
        check("mrs", log_q[4], {CMD_MRS, BA_MODE, 13'h0023});
    endtask : t_init
    task automatic t_sr(input bit burst);
        int i;
        burst_ref_i = burst;
        tick(4);
        log_q.delete();
        sr_req_i = 1;
        for (i = 0; i < 200 && in_sr_o !== 1'b1; i++) tick(1);
        tick(1);
        check("in sr", in_sr_o, 1);
        check("entry refs", log_q.size(), burst ? BUR + 1 : 1);
        check("entry cke", cke_o, 0);
        check("device in sr", sr_m, 1);
        tick(6);
        check("clock stopped", clk_en_o, 0);
        check("cke held", cke_o, 0);
        log_q.delete();
        sr_req_i = 0;
        for (i = 0; i < 200 && ready_o !== 1'b1; i++) tick(1);
        tick(1);
        check("out of sr", in_sr_o, 0);
        check("ready after exit", ready_o, 1);
        check("exit refs", log_q.size(), burst ? BUR : 0);
        check("device out", sr_m, 0);
        check("device faults", faults_m, 0);
    endtask : t_sr
    task automatic conclude();
        if (err_total == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    initial begin
        t_init();
        t_sr(1'b0);
        t_sr(1'b1);
        conclude();
    end
endmodule : sdis_ctrl_bench
`default_nettype wire
